// *** rtl/csv_pkg.sv ***
package csv_pkg;

    // Clock rate and the 50 us base tick of all regulation loops.
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_NS = 50_000;
    localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * TICK_NS / 1_000_000;
    localparam int unsigned TICK_CW = $clog2(TICK_CYC);
    localparam logic [TICK_CW-1:0] TICK_LAST = TICK_CW'(TICK_CYC - 1);

    // Data widths and fixed point scaling of the gains.
    localparam int VAL_W = 32;
    localparam int GAIN_W = 16;
    localparam int GAIN_SHIFT = 8;
    localparam int ADR_W = 10;
    localparam int IDX_W = 8;
    localparam int ADR_LSB = 2;

    // Axis parameter numbers; the byte address is four times the number.
    localparam logic [IDX_W-1:0] P_TGT_POS = 8'h00;
    localparam logic [IDX_W-1:0] P_ACT_POS = 8'h01;
    localparam logic [IDX_W-1:0] P_TGT_VEL = 8'h02;
    localparam logic [IDX_W-1:0] P_ACT_VEL = 8'h03;
    localparam logic [IDX_W-1:0] P_MAX_VEL = 8'h04;
    localparam logic [IDX_W-1:0] P_MAX_CUR = 8'h06;
    localparam logic [IDX_W-1:0] P_TR_VEL = 8'h07;
    localparam logic [IDX_W-1:0] P_STATUS = 8'h08;
    localparam logic [IDX_W-1:0] P_TR_DIST = 8'h0A;
    localparam logic [IDX_W-1:0] P_ACCEL = 8'h0B;
    localparam logic [IDX_W-1:0] P_RAMP_VEL = 8'h0D;
    localparam logic [IDX_W-1:0] P_VEL_MULT = 8'h85;
    localparam logic [IDX_W-1:0] P_CUR_MULT = 8'h86;
    localparam logic [IDX_W-1:0] P_RAMP_EN = 8'h92;
    localparam logic [IDX_W-1:0] P_ACT_CUR = 8'h96;
    localparam logic [IDX_W-1:0] P_TGT_CUR = 8'h9B;
    localparam logic [IDX_W-1:0] P_CUR_KP = 8'hAC;
    localparam logic [IDX_W-1:0] P_CUR_KI = 8'hAD;
    localparam logic [IDX_W-1:0] P_CUR_ESUM = 8'hC9;
    localparam logic [IDX_W-1:0] P_VEL_ESUM = 8'hE5;
    localparam logic [IDX_W-1:0] P_POS_KP = 8'hE6;
    localparam logic [IDX_W-1:0] P_VEL_KP = 8'hEA;
    localparam logic [IDX_W-1:0] P_VEL_KI = 8'hEB;

    // Reset values and fixed limits.
    localparam logic [31:0] MULT_DEF = 32'h0000_0001;
    localparam logic [31:0] MAX_VEL_DEF = 32'h0000_FFFF;
    localparam logic [31:0] MAX_CUR_DEF = 32'h0000_FFFF;
    localparam logic [31:0] SAT_LIM = 32'h7FFF_FFFF;

    // Which quantity software commands last.
    typedef enum logic [1:0] {MODE_CUR, MODE_VEL, MODE_POS} csv_mode_e;

    // Limits a wide value to plus or minus lim (bit 31 of lim ignored).
    function automatic logic signed [31:0] csv_clamp(
        input logic signed [63:0] v, input logic [31:0] lim);
        logic signed [63:0] l;
        logic signed [63:0] nl;
        l = {33'h0, lim[30:0]};
        nl = -l;
        if (v > l)
            return signed'(l[31:0]);
        else if (v < nl)
            return signed'(nl[31:0]);
        return signed'(v[31:0]);
    endfunction

    // Magnitude of a 33-bit signed value.
    function automatic logic [32:0] csv_abs(input logic signed [32:0] v);
        return v[32] ? 33'(-v) : v;
    endfunction

    // Applies the Wishbone byte selects to a stored word.
    function automatic logic [31:0] csv_merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                r[b*8 +: 8] = wd[b*8 +: 8];
        return r;
    endfunction

endpackage

// *** rtl/csv_pi.sv ***
module csv_pi
    import csv_pkg::*;
#(
    parameter int GW = GAIN_W,
    parameter int SH = GAIN_SHIFT
)
(
    input logic clk_i,
    input logic rst_i,
    input logic run_i,
    input logic signed [VAL_W-1:0] target_i,
    input logic signed [VAL_W-1:0] actual_i,
    input logic [GW-1:0] kp_i,
    input logic [GW-1:0] ki_i,
    input logic [VAL_W-1:0] limit_i,
    output logic signed [VAL_W-1:0] out_o,
    output logic signed [VAL_W-1:0] esum_o
);

    ////////////////////////////////////////////////////////////////////////
    // Error, integral and the PI sum, all combinational.

    // The error is one bit wider so a full-scale step cannot wrap.
    logic signed [VAL_W:0] err;
    logic signed [63:0] esum_sum;
    logic signed [63:0] p_term;
    logic signed [63:0] i_term;
    logic signed [63:0] pi_sum;
    logic signed [VAL_W-1:0] next_esum;
    logic signed [VAL_W-1:0] next_out;

    assign err = (VAL_W+1)'(target_i) - (VAL_W+1)'(actual_i);
    assign esum_sum = 64'(esum_o) + 64'(err);
    // The integral stops at full scale instead of wrapping to the far sign.
    assign next_esum = csv_clamp(esum_sum, SAT_LIM);
    assign p_term = 64'($signed({1'b0, kp_i})) * 64'(err);
    assign i_term = 64'($signed({1'b0, ki_i})) * 64'(esum_o);
    assign pi_sum = (p_term + i_term) >>> SH;
    assign next_out = csv_clamp(pi_sum, limit_i);

    ////////////////////////////////////////////////////////////////////////
    // State only moves on the loop's own tick; the output uses the sum
    // from before the update, which costs one tick of lag but keeps the
    // multiplier chain short.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            esum_o <= '0;
            out_o <= '0;
        end
        else if (run_i)
        begin
            esum_o <= next_esum;
            out_o <= next_out;
        end
    end

endmodule

// *** rtl/csv_regulator.sv ***
// The Wishbone register port and the register addresses were chosen for this implementation.
module csv_regulator
    import csv_pkg::*;
(
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [ADR_W-1:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input logic signed [VAL_W-1:0] act_pos_i,
    input logic signed [VAL_W-1:0] act_vel_i,
    input logic signed [VAL_W-1:0] act_cur_i,
    output logic signed [VAL_W-1:0] drive_o,
    output logic pos_end_o
);

    ////////////////////////////////////////////////////////////////////////
    // Software parameters.

    logic signed [31:0] tgt_pos; // Target position.
    logic signed [31:0] tgt_vel; // Target velocity in velocity mode.
    logic signed [31:0] tgt_cur_sw; // Target current in current mode.
    logic [31:0] max_vel; // Velocity limit.
    logic [31:0] max_cur; // Current limit.
    logic [31:0] tr_vel; // Target reached velocity.
    logic [31:0] tr_dist; // Target reached distance.
    logic [31:0] accel; // Ramp step per velocity tick.
    logic [31:0] vel_mult; // Velocity and position loop multiplier.
    logic [31:0] cur_mult; // Current loop multiplier.
    logic [31:0] cur_kp, cur_ki, pos_kp, vel_kp, vel_ki; // Gains.
    logic ramp_en; // Ramp generator switch.
    csv_mode_e mode; // Last commanded quantity.

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic [IDX_W-1:0] wb_idx;
    logic wb_req;
    logic wr_en;
    logic pos_wr;
    logic [31:0] rd_val;

    assign wb_idx = wb_adr_i[ADR_LSB +: IDX_W];
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = wb_req && wb_we_i;
    assign pos_wr = wr_en && (wb_idx == P_TGT_POS);

    // Every access is answered one cycle later, mapped or not.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    // Read data is captured with the request so it stands with ack.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= '0;
        else if (wb_req && !wb_we_i)
            wb_dat_o <= rd_val;
    end

    ////////////////////////////////////////////////////////////////////////
    // Parameter writes, honouring the byte selects.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tgt_pos <= '0;
            tgt_vel <= '0;
            tgt_cur_sw <= '0;
            max_vel <= MAX_VEL_DEF;
            max_cur <= MAX_CUR_DEF;
            tr_vel <= '0;
            tr_dist <= '0;
            accel <= '0;
            vel_mult <= MULT_DEF;
            cur_mult <= MULT_DEF;
            cur_kp <= '0;
            cur_ki <= '0;
            pos_kp <= '0;
            vel_kp <= '0;
            vel_ki <= '0;
            ramp_en <= 1'b0;
        end
        else if (wr_en)
        begin
            case (wb_idx)
                P_TGT_POS: tgt_pos <= csv_merge(tgt_pos, wb_dat_i, wb_sel_i);
                P_TGT_VEL: tgt_vel <= csv_merge(tgt_vel, wb_dat_i, wb_sel_i);
                P_TGT_CUR: tgt_cur_sw <= csv_merge(tgt_cur_sw, wb_dat_i,
                    wb_sel_i);
                P_MAX_VEL: max_vel <= csv_merge(max_vel, wb_dat_i, wb_sel_i);
                P_MAX_CUR: max_cur <= csv_merge(max_cur, wb_dat_i, wb_sel_i);
                P_TR_VEL: tr_vel <= csv_merge(tr_vel, wb_dat_i, wb_sel_i);
                P_TR_DIST: tr_dist <= csv_merge(tr_dist, wb_dat_i, wb_sel_i);
                P_ACCEL: accel <= csv_merge(accel, wb_dat_i, wb_sel_i);
                P_VEL_MULT: vel_mult <= csv_merge(vel_mult, wb_dat_i,
                    wb_sel_i);
                P_CUR_MULT: cur_mult <= csv_merge(cur_mult, wb_dat_i,
                    wb_sel_i);
                P_CUR_KP: cur_kp <= csv_merge(cur_kp, wb_dat_i, wb_sel_i);
                P_CUR_KI: cur_ki <= csv_merge(cur_ki, wb_dat_i, wb_sel_i);
                P_POS_KP: pos_kp <= csv_merge(pos_kp, wb_dat_i, wb_sel_i);
                P_VEL_KP: vel_kp <= csv_merge(vel_kp, wb_dat_i, wb_sel_i);
                P_VEL_KI: vel_ki <= csv_merge(vel_ki, wb_dat_i, wb_sel_i);
                P_RAMP_EN: ramp_en <= wb_sel_i[0] ? wb_dat_i[0] : ramp_en;
                default: ;
            endcase
        end
    end

    // Writing a target selects what the cascade regulates.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode <= MODE_CUR;
        else if (pos_wr)
            mode <= MODE_POS;
        else if (wr_en && wb_idx == P_TGT_VEL)
            mode <= MODE_VEL;
        else if (wr_en && wb_idx == P_TGT_CUR)
            mode <= MODE_CUR;
    end

    ////////////////////////////////////////////////////////////////////////
    // Base tick and the two loop dividers (0: velocity/position, 1: current).

    localparam int NL = 2;
    logic [TICK_CW-1:0] base_cnt;
    logic base_tick;
    logic [NL-1:0][31:0] mult_v;
    logic [NL-1:0] ltick;

    assign base_tick = (base_cnt == TICK_LAST);
    assign mult_v = {cur_mult, vel_mult};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            base_cnt <= '0;
        else
            base_cnt <= base_tick ? '0 : base_cnt + 1'b1;
    end

    // A multiplier of zero behaves as one; lowering it takes effect at once.
    for (genvar g = 0; g < NL; g++)
    begin : g_div
        logic [31:0] cnt;
        logic at_end;
        assign at_end = (cnt + 32'h1 >= mult_v[g]);
        assign ltick[g] = base_tick && at_end;
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
                cnt <= '0;
            else if (base_tick)
                cnt <= at_end ? '0 : cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Position loop and brake point.

    logic signed [31:0] ramp_vel;
    logic signed [32:0] pos_err;
    logic [32:0] pos_err_abs;
    logic signed [63:0] pos_prod;
    logic signed [31:0] pos_vel;
    logic [32:0] ramp_abs;
    logic [65:0] v_sq;
    logic [65:0] stop_dist;
    logic brake;
    logic signed [31:0] vel_set;

    assign pos_err = 33'(tgt_pos) - 33'(act_pos_i);
    assign pos_err_abs = csv_abs(pos_err);
    assign pos_prod = 64'($signed({1'b0, pos_kp[GAIN_W-1:0]})) * 64'(pos_err);
    // Without the ramp this saturates at the limit: full speed moves.
    assign pos_vel = csv_clamp(pos_prod >>> GAIN_SHIFT, max_vel);
    // Braking starts once v*v reaches 2*a*d, the distance still needed
    // to stop at the present ramp velocity.
    assign ramp_abs = csv_abs(33'(ramp_vel));
    assign v_sq = 66'(ramp_abs) * 66'(ramp_abs);
    assign stop_dist = 66'({accel[30:0], 1'b0}) * 66'(pos_err_abs);
    assign brake = ramp_en && (v_sq >= stop_dist);
    assign vel_set = (mode == MODE_POS) ? (brake ? '0 : pos_vel)
        : csv_clamp(64'(tgt_vel), max_vel);

    ////////////////////////////////////////////////////////////////////////
    // Velocity ramp generator.

    logic signed [32:0] ramp_diff;
    logic signed [32:0] acc_s;
    logic signed [63:0] ramp_step;
    logic signed [31:0] next_ramp;

    assign ramp_diff = 33'(vel_set) - 33'(ramp_vel);
    assign acc_s = {2'b00, accel[30:0]};
    assign ramp_step = (ramp_diff > acc_s) ? 64'(ramp_vel) + 64'(acc_s)
        : (ramp_diff < -acc_s) ? 64'(ramp_vel) - 64'(acc_s)
        : 64'(vel_set);
    assign next_ramp = ramp_en ? csv_clamp(ramp_step, max_vel)
        : vel_set;

    // The ramp only steps on the velocity tick so acceleration is per tick.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ramp_vel <= '0;
        else if (ltick[0])
            ramp_vel <= next_ramp;
    end

    ////////////////////////////////////////////////////////////////////////
    // Velocity and current regulators.

    logic signed [31:0] vel_out;
    logic signed [31:0] vel_esum;
    logic signed [31:0] cur_esum;
    logic signed [31:0] cur_tgt;

    // The velocity loop idles in current mode, so its sum does not wind up.
    csv_pi u_vel_pi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(ltick[0] && mode != MODE_CUR),
        .target_i(ramp_vel),
        .actual_i(act_vel_i),
        .kp_i(vel_kp[GAIN_W-1:0]),
        .ki_i(vel_ki[GAIN_W-1:0]),
        .limit_i(max_cur),
        .out_o(vel_out),
        .esum_o(vel_esum)
    );

    assign cur_tgt = (mode == MODE_CUR) ? csv_clamp(64'(tgt_cur_sw), max_cur)
        : vel_out;

    csv_pi u_cur_pi (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(ltick[1]),
        .target_i(cur_tgt),
        .actual_i(act_cur_i),
        .kp_i(cur_kp[GAIN_W-1:0]),
        .ki_i(cur_ki[GAIN_W-1:0]),
        .limit_i(SAT_LIM),
        .out_o(drive_o),
        .esum_o(cur_esum)
    );

    ////////////////////////////////////////////////////////////////////////
    // Position end flag.

    logic dist_ok;
    logic vel_ok;

    assign dist_ok = (pos_err_abs <= 33'(tr_dist));
    assign vel_ok = (csv_abs(33'(act_vel_i)) <= 33'(tr_vel));

    // A new target clears the flag even on a tick, because that tick still
    // judged the old target.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pos_end_o <= 1'b0;
        else if (pos_wr)
            pos_end_o <= 1'b0;
        else if (ltick[0] && mode == MODE_POS)
            pos_end_o <= dist_ok && vel_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read selection.
    always_comb
    begin
        case (wb_idx)
            P_TGT_POS: rd_val = tgt_pos;
            P_ACT_POS: rd_val = act_pos_i;
            P_TGT_VEL: rd_val = tgt_vel;
            P_ACT_VEL: rd_val = act_vel_i;
            P_MAX_VEL: rd_val = max_vel;
            P_MAX_CUR: rd_val = max_cur;
            P_TR_VEL: rd_val = tr_vel;
            P_STATUS: rd_val = {31'h0, pos_end_o};
            P_TR_DIST: rd_val = tr_dist;
            P_ACCEL: rd_val = accel;
            P_RAMP_VEL: rd_val = ramp_vel;
            P_VEL_MULT: rd_val = vel_mult;
            P_CUR_MULT: rd_val = cur_mult;
            P_RAMP_EN: rd_val = {31'h0, ramp_en};
            P_ACT_CUR: rd_val = act_cur_i;
            P_TGT_CUR: rd_val = cur_tgt;
            P_CUR_KP: rd_val = cur_kp;
            P_CUR_KI: rd_val = cur_ki;
            P_CUR_ESUM: rd_val = cur_esum;
            P_VEL_ESUM: rd_val = vel_esum;
            P_POS_KP: rd_val = pos_kp;
            P_VEL_KP: rd_val = vel_kp;
            P_VEL_KI: rd_val = vel_ki;
            default: rd_val = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_answer_a: assert property (wb_req_s |=> ack_pulse_s)
        else $error("bus request not answered by a one-cycle ack");
    vel_rate_a: assert property (ltick[0] |-> base_tick)
        else $error("velocity tick off the base tick");
    cur_rate_a: assert property (ltick[1] |-> base_tick)
        else $error("current tick off the base tick");
    cur_clamp_a: assert property (mode == MODE_CUR |->
        csv_abs(33'(cur_tgt)) <= 33'(max_cur[30:0]))
        else $error("current target above limit");
    vel_clamp_a: assert property (
        csv_abs(33'(vel_set)) <= 33'(max_vel[30:0]))
        else $error("velocity target above limit");
    ramp_bypass_a: assert property (ltick[0] && !ramp_en |=>
        ramp_vel == $past(vel_set))
        else $error("ramp off but target not passed through");
    ramp_slope_a: assert property (ltick[0] && ramp_en &&
        csv_abs(33'(ramp_vel)) <= 33'(max_vel[30:0]) |->
        csv_abs(33'(next_ramp) - 33'(ramp_vel)) <= 33'(accel[30:0]))
        else $error("ramp step larger than acceleration");
    pos_clear_a: assert property (pos_wr |=> !pos_end_o)
        else $error("position end flag not cleared by new target");
    end_dist_a: assert property ($rose(pos_end_o) |-> $past(dist_ok))
        else $error("end flag set outside distance");
    end_vel_a: assert property ($rose(pos_end_o) |-> $past(vel_ok))
        else $error("end flag set above velocity limit");

endmodule

// *** sim/csv_motor_model.sv ***
module csv_motor_model
    import csv_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic signed [VAL_W-1:0] drive_i,
    input wire logic frc_i,
    input wire logic signed [VAL_W-1:0] f_pos_i,
    input wire logic signed [VAL_W-1:0] f_vel_i,
    input wire logic signed [VAL_W-1:0] f_cur_i,
    output logic signed [VAL_W-1:0] pos_o,
    output logic signed [VAL_W-1:0] vel_o,
    output logic signed [VAL_W-1:0] cur_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Internal state of a crude motor with inertia.
    logic signed [VAL_W-1:0] pos;
    logic signed [VAL_W-1:0] vel;
    logic signed [VAL_W-1:0] cur;

    ////////////////////////////////////////////////////////////////////////
    // Current lags the drive by one clock, speed integrates the current.
    // The shifts keep the free motion slow, so loops see a sluggish load.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pos <= '0;
            vel <= '0;
            cur <= '0;
        end
        else
        begin
            cur <= drive_i;
            vel <= vel + (cur >>> 10);
            pos <= pos + (vel >>> 4);
        end
    end

    // The bench may pin the feedback to exact figures for exact results.
    assign pos_o = frc_i ? f_pos_i : pos;
    assign vel_o = frc_i ? f_vel_i : vel;
    assign cur_o = frc_i ? f_cur_i : cur;
endmodule

// *** sim/csv_regulator_tb_top.sv ***
module csv_regulator_tb_top
    import csv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic signed [VAL_W-1:0] drive;
    logic signed [VAL_W-1:0] apos;
    logic signed [VAL_W-1:0] avel;
    logic signed [VAL_W-1:0] acur;
    logic pos_end;
    // Feedback override towards the motor model.
    logic frc = 1'b0;
    logic signed [VAL_W-1:0] f_pos = '0;
    logic signed [VAL_W-1:0] f_vel = '0;
    logic signed [VAL_W-1:0] f_cur = '0;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc_cnt = 0;

    csv_regulator u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .act_pos_i(apos), .act_vel_i(avel), .act_cur_i(acur),
        .drive_o(drive), .pos_end_o(pos_end));

    csv_motor_model u_motor (.clk_i(clk_i), .rst_i(rst_i), .drive_i(drive),
        .frc_i(frc), .f_pos_i(f_pos), .f_vel_i(f_vel), .f_cur_i(f_cur),
        .pos_o(apos), .vel_o(avel), .cur_o(acur));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 25 MHz and a free cycle count for measuring loop periods.
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc_cnt++;

    ////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks.
    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A wait that runs out counts as a mismatch and ends the run.
    task automatic give_up();
        check(32'h0, 32'h1);
        summarize();
    endtask

    // One classic cycle; ack is judged with the value sampled at the edge.
    task automatic wb(input logic w, input logic [7:0] idx,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        sel <= 4'hF;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1)
            give_up();
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        wb(1'b0, idx, 32'h0, q);
    endtask

    // Reads a parameter until it leaves its old value.
    task automatic poll(input logic [7:0] idx, input logic [31:0] old,
        output logic [31:0] q);
        int n;
        n = 0;
        do
        begin
            rd(idx, q);
            n++;
        end
        while (q === old && n < 2000);
        if (q === old)
            give_up();
    endtask

    // Counts clocks until the drive output moves.
    task automatic wait_drive(output int c);
        logic [31:0] old;
        old = drive;
        c = 0;
        do
        begin
            @(posedge clk_i);
            c++;
        end
        while (drive === old && c < 10000);
        if (drive === old)
            give_up();
    endtask

    task automatic wait_end(input logic lvl);
        int n;
        n = 0;
        while (pos_end !== lvl && n < 3000)
        begin
            @(posedge clk_i);
            n++;
        end
        if (pos_end !== lvl)
            give_up();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset values, an unmapped index and a read-only sum.
    task automatic t_reset();
        logic [7:0] ri [8] = '{P_MAX_VEL, P_MAX_CUR, P_VEL_MULT, P_CUR_MULT,
            P_CUR_ESUM, P_VEL_ESUM, P_TGT_CUR, 8'hFF};
        logic [31:0] re [8] = '{MAX_VEL_DEF, MAX_CUR_DEF, MULT_DEF,
            MULT_DEF, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] q;
        check(drive, 32'h0);
        check(pos_end, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            rd(ri[i], q);
            check(q, re[i]);
        end
        wr(P_VEL_ESUM, 32'h0000_04D2);
        rd(P_VEL_ESUM, q);
        check(q, 32'h0);
    endtask

    // Ramp steps per velocity tick, tick period, bypass and limit.
    task automatic t_ramp();
        logic [31:0] q;
        int t0;
        wr(P_VEL_MULT, 32'h2);
        wr(P_ACCEL, 32'hA);
        wr(P_RAMP_EN, 32'h1);
        wr(P_TGT_VEL, 32'h3E8);
        poll(P_RAMP_VEL, 32'h0, q);
        check(q, 32'hA);
        t0 = cyc_cnt;
        poll(P_RAMP_VEL, 32'hA, q);
        check(q, 32'h14);
        check(32'(cyc_cnt - t0 > 2494 && cyc_cnt - t0 < 2506), 32'h1);
        wr(P_VEL_MULT, 32'h1);
        wr(P_MAX_VEL, 32'h12C);
        wr(P_RAMP_EN, 32'h0);
        poll(P_RAMP_VEL, 32'h14, q);
        check(q, 32'h12C);
    endtask

    // Current PI with a clamped target and a slowed loop.
    task automatic t_current();
        logic [31:0] q;
        int c;
        frc <= 1'b1;
        f_cur <= 32'sd40;
        f_pos <= 32'sd1000;
        wr(P_MAX_CUR, 32'h64);
        wr(P_CUR_MULT, 32'h3);
        wr(P_TGT_CUR, 32'h1F4);
        rd(P_TGT_CUR, q);
        check(q, 32'h64);
        wr(P_CUR_KP, 32'h100);
        wait_drive(c);
        check(drive, 32'h3C);
        wr(P_CUR_KI, 32'h100);
        wait_drive(c);
        wait_drive(c);
        check(32'(c), 32'd3750);
        rd(P_CUR_ESUM, q);
        check(32'(q != 0 && q % 60 == 0), 32'h1);
        wr(P_CUR_KI, 32'h0);
        wr(P_CUR_MULT, 32'h1);
        // A huge error must pin the sum at full scale, not wrap it.
        f_cur <= 32'sh8000_0001;
        wr(P_MAX_CUR, 32'h7FFF_FFFF);
        wr(P_TGT_CUR, 32'h7FFF_FFFF);
        repeat (2600) @(posedge clk_i);
        check(drive, 32'h7FFF_FFFF);
        rd(P_CUR_ESUM, q);
        check(q, 32'h7FFF_FFFF);
    endtask

    // End flag at the distance boundary, speed gate, new target.
    task automatic t_position();
        logic [31:0] q;
        wr(P_POS_KP, 32'h100);
        wr(P_TR_DIST, 32'h5);
        wr(P_TR_VEL, 32'h0);
        wr(P_TGT_POS, 32'h3ED);
        check(pos_end, 32'h0);
        wait_end(1'b1);
        rd(P_STATUS, q);
        check(q, 32'h1);
        rd(P_RAMP_VEL, q);
        check(q, 32'h5);
        f_vel <= 32'sd2;
        rd(P_ACT_VEL, q);
        check(q, 32'h2);
        wait_end(1'b0);
        check(pos_end, 32'h0);
        f_vel <= 32'sd0;
        wait_end(1'b1);
        wr(P_TGT_POS, 32'h7D0);
        check(pos_end, 32'h0);
        poll(P_RAMP_VEL, 32'h5, q);
        check(q, 32'h12C);
        repeat (2600) @(posedge clk_i);
        check(pos_end, 32'h0);
        // At 300 and a step of 45, v*v meets 2*a*d for 1000 left: brake.
        wr(P_ACCEL, 32'h2D);
        wr(P_RAMP_EN, 32'h1);
        poll(P_RAMP_VEL, 32'h12C, q);
        check(q, 32'hFF);
    endtask

    // Reset in mid-run clears sums and drive; velocity PI feeds current.
    task automatic t_rerun();
        logic [31:0] q;
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(drive, 32'h0);
        rd(P_CUR_ESUM, q);
        check(q, 32'h0);
        rd(P_VEL_ESUM, q);
        check(q, 32'h0);
        wr(P_VEL_KP, 32'h100);
        wr(P_MAX_CUR, 32'h64);
        wr(P_TGT_VEL, 32'h3E8);
        poll(P_TGT_CUR, 32'h0, q);
        check(q, 32'h64);
        rd(P_VEL_ESUM, q);
        check(q, 32'h3E8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: five clocks of reset, then every scenario in turn.
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_ramp();
        t_current();
        t_position();
        t_rerun();
        summarize();
    end
endmodule
